// ---- psat_cfg.svh ----
`ifndef PSAT_CFG_SVH
`define PSAT_CFG_SVH

// ==========================================
// command codes
`define PSAT_CMD_ALERT_MASK    8'hdb
`define PSAT_CMD_LOOP_TUNING   8'hdf

// ==========================================
// lengths in bytes
`define PSAT_MASK_BYTES        4'h7
`define PSAT_TUNING_BYTES      4'h4

// ==========================================
// field positions
`define PSAT_INTEG_HI          31
`define PSAT_INTEG_LO          24
`define PSAT_RESID_HI          23
`define PSAT_RESID_LO          16
`define PSAT_GAIN_HI           15
`define PSAT_GAIN_LO           0
`define PSAT_UNUSED_STATUS     5

// ==========================================
// reset values
`define PSAT_MASK_RESET        56'h00_0000_0000_0000
`define PSAT_INTEG_RESET       8'h50
`define PSAT_RESID_RESET       8'h50
`define PSAT_GAIN_RESET        16'h010e

`endif

// ---- psat_pkg.sv ----
package psat_pkg;

   // one status byte per fault class
   typedef struct packed {
      logic [7:0] vendor;
      logic [7:0] unused;
      logic [7:0] cml;
      logic [7:0] temperature;
      logic [7:0] input_side;
      logic [7:0] iout;
      logic [7:0] vout;
   } psat_status_t;

   typedef struct packed {
      logic [7:0]  integral_gain;
      logic [7:0]  residual;
      logic [15:0] loop_gain;
   } psat_tuning_t;

   typedef enum logic [1:0] {
      PSAT_SEL_NONE,
      PSAT_SEL_MASK,
      PSAT_SEL_TUNING
   } psat_sel_t;

endpackage : psat_pkg

// ---- psat_alert_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "psat_cfg.svh"

module psat_alert_gate
   import psat_pkg::*;
(
   input  wire logic         ref_clk_in,
   input  wire logic         srst_in,
   input  wire psat_status_t fault_status_in,
   input  wire logic [55:0]  mask_in,
   output logic              fault_alert_out,
   output logic [6:0]        byte_alert_out
);

   logic [55:0] status_flat;
   logic [6:0]  next_byte_alert;

   assign status_flat = fault_status_in;

   // ==========================================
   // per status byte gating
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_byte
         if (g == `PSAT_UNUSED_STATUS) begin : g_unused
            assign next_byte_alert[g] = 1'b0;
         end else begin : g_used
            // masked bits still sit in status, only fault_alert_out and byte_alert_out are held off
            assign next_byte_alert[g] =
               |(status_flat[g*8 +: 8] & ~mask_in[g*8 +: 8]);
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         byte_alert_out  <= 7'h00;
         fault_alert_out <= 1'b0;
      end else begin
         byte_alert_out  <= next_byte_alert;
         fault_alert_out <= |next_byte_alert;
      end
   end

endmodule : psat_alert_gate

`default_nettype wire

// ---- psat_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "psat_cfg.svh"

module psat_top
   import psat_pkg::*;
(
   input  wire logic         ref_clk_in,
   input  wire logic         srst_in,
   // command framing from the management engine
   input  wire logic         cmd_start_in,
   input  wire logic [7:0]   cmd_code_in,
   input  wire logic         wr_byte_valid_in,
   input  wire logic [7:0]   wr_byte_in,
   input  wire logic         wr_stop_in,
   input  wire logic         rd_start_in,
   input  wire logic         rd_byte_req_in,
   output logic [7:0]        rd_byte_out,
   output logic              rd_byte_valid_out,
   output logic              cmd_nack_out,
   output logic              wr_done_out,
   // default tuning derived from input and output voltage
   input  wire logic         dflt_load_in,
   input  wire logic [7:0]   dflt_residual_in,
   input  wire logic [15:0]  dflt_gain_in,
   // faults and results
   input  wire psat_status_t fault_status_in,
   output logic              fault_alert_out,
   output logic [6:0]        alert_byte_out,
   output psat_tuning_t      loop_tuning_out,
   output logic              host_override_out
);

   // ==========================================
   // storage
   logic [55:0]  alert_source_mask;
   psat_tuning_t loop_tuning_config;
   logic         host_override;
   psat_sel_t    wr_sel;
   logic [55:0]  wr_shadow;
   logic [3:0]   wr_count;
   logic         wr_overrun;
   logic [55:0]  rd_shift;
   logic [3:0]   rd_left;

   psat_sel_t    next_sel;
   logic         commit_mask;
   logic         commit_tuning;
   logic         bad_length;

   always_comb begin
      unique case (cmd_code_in)
         `PSAT_CMD_ALERT_MASK:  next_sel = PSAT_SEL_MASK;
         `PSAT_CMD_LOOP_TUNING: next_sel = PSAT_SEL_TUNING;
         default:               next_sel = PSAT_SEL_NONE;
      endcase
   end

   // ==========================================
   // write framing, bytes arrive low byte first
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         wr_sel <= PSAT_SEL_NONE;
      end else if (cmd_start_in) begin
         wr_sel <= next_sel;
      end else if (wr_stop_in) begin
         wr_sel <= PSAT_SEL_NONE;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         wr_shadow  <= 56'h0;
         wr_count   <= 4'h0;
         wr_overrun <= 1'b0;
      end else if (cmd_start_in) begin
         wr_shadow  <= 56'h0;
         wr_count   <= 4'h0;
         wr_overrun <= 1'b0;
      end else if (wr_byte_valid_in) begin
         if (wr_count < `PSAT_MASK_BYTES) begin
            wr_shadow[wr_count*8 +: 8] <= wr_byte_in;
            wr_count                   <= wr_count + 4'h1;
         end else begin
            // extra bytes would wrap onto low bytes; refuse the frame
            wr_overrun <= 1'b1;
         end
      end
   end

   // a short or long frame never half-updates a register
   assign commit_mask   = wr_stop_in && (wr_sel == PSAT_SEL_MASK) && !wr_overrun
                          && (wr_count == `PSAT_MASK_BYTES);
   assign commit_tuning = wr_stop_in && (wr_sel == PSAT_SEL_TUNING) && !wr_overrun
                          && (wr_count == `PSAT_TUNING_BYTES);
   assign bad_length    = wr_stop_in && (wr_sel != PSAT_SEL_NONE)
                          && !commit_mask && !commit_tuning;

   // ==========================================
   // alert source mask
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         alert_source_mask <= `PSAT_MASK_RESET;
      end else if (commit_mask) begin
         alert_source_mask <= wr_shadow;
      end
   end

   // ==========================================
   // loop tuning
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         loop_tuning_config.integral_gain <= `PSAT_INTEG_RESET;
         loop_tuning_config.residual      <= `PSAT_RESID_RESET;
         loop_tuning_config.loop_gain     <= `PSAT_GAIN_RESET;
      end else if (commit_tuning) begin
         // values outside the typical span are stored as written
         loop_tuning_config.integral_gain <=
            wr_shadow[`PSAT_INTEG_HI:`PSAT_INTEG_LO];
         loop_tuning_config.residual      <=
            wr_shadow[`PSAT_RESID_HI:`PSAT_RESID_LO];
         loop_tuning_config.loop_gain     <=
            wr_shadow[`PSAT_GAIN_HI:`PSAT_GAIN_LO];
      end else if (dflt_load_in && !host_override) begin
         loop_tuning_config.residual  <= dflt_residual_in;
         loop_tuning_config.loop_gain <= dflt_gain_in;
      end
   end

   // once the host has written, derived defaults no longer apply
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         host_override <= 1'b0;
      end else if (commit_tuning) begin
         host_override <= 1'b1;
      end
   end

   // ==========================================
   // read framing, low byte first
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rd_shift <= 56'h0;
         rd_left  <= 4'h0;
      end else if (rd_start_in) begin
         unique case (next_sel)
            PSAT_SEL_MASK: begin
               rd_shift <= alert_source_mask;
               rd_left  <= `PSAT_MASK_BYTES;
            end
            PSAT_SEL_TUNING: begin
               rd_shift <= {24'h0, loop_tuning_config};
               rd_left  <= `PSAT_TUNING_BYTES;
            end
            PSAT_SEL_NONE: begin
               rd_shift <= 56'h0;
               rd_left  <= 4'h0;
            end
         endcase
      end else if (rd_byte_req_in && (rd_left != 4'h0)) begin
         rd_shift <= {8'h00, rd_shift[55:8]};
         rd_left  <= rd_left - 4'h1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rd_byte_out       <= 8'h00;
         rd_byte_valid_out <= 1'b0;
      end else begin
         rd_byte_valid_out <= rd_byte_req_in && !rd_start_in && (rd_left != 4'h0);
         // past the end the host reads zero filler
         rd_byte_out       <= (rd_byte_req_in && !rd_start_in && (rd_left != 4'h0))
                              ? rd_shift[7:0] : 8'h00;
      end
   end

   // ==========================================
   // command status
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         cmd_nack_out <= 1'b0;
         wr_done_out  <= 1'b0;
      end else begin
         cmd_nack_out <= ((cmd_start_in || rd_start_in) && (next_sel == PSAT_SEL_NONE))
                         || bad_length;
         wr_done_out  <= commit_mask || commit_tuning;
      end
   end

   // ==========================================
   // alert gating
   psat_alert_gate u_gate (
      .ref_clk_in      (ref_clk_in),
      .srst_in         (srst_in),
      .fault_status_in (fault_status_in),
      .mask_in         (alert_source_mask),
      .fault_alert_out (fault_alert_out),
      .byte_alert_out  (alert_byte_out)
   );

   assign loop_tuning_out   = loop_tuning_config;
   assign host_override_out = host_override;

endmodule : psat_top

`default_nettype wire

// ---- psat_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checks
module psat_checker
   import psat_pkg::*;
(
   input wire logic         ref_clk_in,
   input wire logic         srst_in,
   input wire logic         wr_stop_in,
   input wire logic         dflt_load_in,
   input wire logic [7:0]   dflt_residual_in,
   input wire logic [15:0]  dflt_gain_in,
   input wire psat_status_t fault_status_in,
   input wire logic         wr_done_out,
   input wire logic         fault_alert_out,
   input wire logic [6:0]   alert_byte_out,
   input wire psat_tuning_t loop_tuning_out,
   input wire logic         host_override_out
);
   logic [6:0] nz;
   logic       mask_clear;
   always_comb for (int i = 0; i < 7; i++) nz[i] = |fault_status_in[8*i +: 8];
   // a mask commit may set mask bits and wr_done_out also marks tuning commits, so the exact check stops at the first commit of either kind
   always_ff @(posedge ref_clk_in) mask_clear <= srst_in | (mask_clear & ~wr_done_out);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   alert_any_a: assert property (fault_alert_out == (alert_byte_out != 7'h00))
      else $error("alert pin mismatch");
   unused_byte_a: assert property (alert_byte_out[5] == 1'b0)
      else $error("unused byte alerts");
   masked_quiet_a: assert property (!$past(srst_in) |-> (alert_byte_out & ~$past(nz)) == 7'h00)
      else $error("alert without fault");
   clear_mask_a: assert property (mask_clear && !$past(srst_in) |->
      alert_byte_out == ($past(nz) & 7'h5f)) else $error("unmasked fault lost");
   done_cause_a: assert property (wr_done_out |-> $past(wr_stop_in))
      else $error("done without stop");
   override_set_a: assert property ($rose(host_override_out) |-> wr_done_out)
      else $error("override without commit");
   tuning_cause_a: assert property ($changed(loop_tuning_out) && !$past(srst_in) |->
      wr_done_out || $past(dflt_load_in)) else $error("tuning changed alone");
   dflt_take_a: assert property ($past(dflt_load_in) && !$past(host_override_out)
      && !$past(srst_in) && !wr_done_out |-> loop_tuning_out == {$past(loop_tuning_out[31:24]),
      $past(dflt_residual_in), $past(dflt_gain_in)}) else $error("default not loaded");
endmodule : psat_checker
bind psat_top psat_checker i_checker (.ref_clk_in, .srst_in, .wr_stop_in, .dflt_load_in,
   .dflt_residual_in, .dflt_gain_in, .fault_status_in, .wr_done_out, .fault_alert_out,
   .alert_byte_out, .loop_tuning_out, .host_override_out);
`default_nettype wire

// ---- psat_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// host side of the command port
module psat_host_model (
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] rd_byte_in,
   input  wire logic       rd_valid_in,
   input  wire logic       nack_in,
   input  wire logic       done_in,
   output logic            start_out,
   output logic            rd_start_out,
   output logic            req_out,
   output logic            wvalid_out,
   output logic            stop_out,
   output logic [7:0]      code_out,
   output logic [7:0]      byte_out
);
   initial begin
      {start_out, rd_start_out, req_out, wvalid_out, stop_out} = 5'h00;
      code_out = 8'h00;
      byte_out = 8'h00;
   end
   // idle code and data lines flip so a stale value never passes for a live one
   task automatic wr(input logic [7:0] c, input int n, input logic [63:0] d,
                     output logic [1:0] r);
      r = 2'h0;
      start_out = 1'b1;
      code_out = c;
      for (int k = 0; k <= n; k++) begin
         @(negedge ref_clk_in);
         r[0] = r[0] | nack_in;
         start_out = 1'b0;
         code_out = ~c;
         wvalid_out = (k < n);
         byte_out = (k < n) ? d[8*k +: 8] : ~byte_out;
         stop_out = (k == n);
      end
      @(negedge ref_clk_in);
      r = {done_in, r[0] | nack_in};
      stop_out = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] c, input int n, output logic [63:0] d,
                     output logic [7:0] v);
      d = 64'h0;
      v = 8'h00;
      rd_start_out = 1'b1;
      code_out = c;
      @(negedge ref_clk_in);
      rd_start_out = 1'b0;
      code_out = ~c;
      req_out = 1'b1;
      for (int k = 0; k < n; k++) begin
         @(negedge ref_clk_in);
         req_out = (k < n - 1);
         v[k] = rd_valid_in;
         d[8*k +: 8] = rd_byte_in;
      end
   endtask : rd
endmodule : psat_host_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "psat_cfg.svh"
module testbench
   import psat_pkg::*;
;
   logic         ref_clk_in = 1'b0;
   logic         srst_in = 1'b1;
   logic         start, rd_go, req, wv, stop, rv, nack, done, alert, ovr, dload;
   logic [7:0]   code, wb, rb, dres, v;
   logic [15:0]  dgain;
   logic [6:0]   abyte;
   psat_status_t fault;
   psat_tuning_t tune, exp_t;
   logic [31:0]  seed = 32'h73b7c5bc;
   logic [63:0]  d, m, x;
   logic [1:0]   r;
   int           failures = 0;
   int           n_compared = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   psat_top i_dut (.ref_clk_in, .srst_in, .cmd_start_in(start), .cmd_code_in(code),
      .wr_byte_valid_in(wv), .wr_byte_in(wb), .wr_stop_in(stop), .rd_start_in(rd_go),
      .rd_byte_req_in(req), .rd_byte_out(rb), .rd_byte_valid_out(rv), .cmd_nack_out(nack),
      .wr_done_out(done), .dflt_load_in(dload), .dflt_residual_in(dres), .dflt_gain_in(dgain),
      .fault_status_in(fault), .fault_alert_out(alert), .alert_byte_out(abyte),
      .loop_tuning_out(tune), .host_override_out(ovr));
   psat_host_model i_host (.ref_clk_in, .rd_byte_in(rb), .rd_valid_in(rv), .nack_in(nack),
      .done_in(done), .start_out(start), .rd_start_out(rd_go), .req_out(req),
      .wvalid_out(wv), .stop_out(stop), .code_out(code), .byte_out(wb));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic logic [6:0] exp_alert(input logic [55:0] f, input logic [55:0] mk);
      logic [6:0] e;
      for (int i = 0; i < 7; i++) e[i] = |(f[8*i +: 8] & ~mk[8*i +: 8]);
      e[`PSAT_UNUSED_STATUS] = 1'b0;
      return e;
   endfunction : exp_alert
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      dload = 1'b0;
      dres = 8'h00;
      dgain = 16'h0000;
      fault = '0;
      repeat (16) @(negedge ref_clk_in);
      srst_in = 1'b0;
      chk({ovr, tune}, {1'b0, `PSAT_INTEG_RESET, `PSAT_RESID_RESET, `PSAT_GAIN_RESET});
      for (int t = 0; t < 14; t++) begin
         m = (t < 2) ? {8'h00, {56{t[0]}}} : ({rnd(), rnd()} & 64'h00ff_ffff_ffff_ffff);
         if (t > 0) i_host.wr(`PSAT_CMD_ALERT_MASK, 7, m, r);
         if (t > 0) chk(r, 2'h2);
         i_host.rd(`PSAT_CMD_ALERT_MASK, 8, d, v);
         chk({v, d}, {8'h7f, m});
         x = {rnd(), rnd()};
         fault = x[55:0];
         @(negedge ref_clk_in);
         chk({alert, abyte}, {|exp_alert(fault, m[55:0]), exp_alert(fault, m[55:0])});
      end
      $display("mask and alert test done");
      i_host.wr(`PSAT_CMD_ALERT_MASK, 6, ~m, r);
      chk(r, 2'h1);
      i_host.wr(8'hde, 4, ~m, r);
      chk(r, 2'h1);
      i_host.rd(`PSAT_CMD_ALERT_MASK, 7, d, v);
      chk({v, d}, {8'h7f, m});
      $display("refusal test done");
      x = {rnd(), rnd()};
      dres = 8'd10 + {2'h0, x[37:32]};
      dgain = 16'd100 + {7'h00, x[8:0]};
      dload = 1'b1;
      @(negedge ref_clk_in);
      dload = 1'b0;
      chk(tune, {`PSAT_INTEG_RESET, dres, dgain});
      exp_t = x[31:0] & 32'h7f7f_ffff;
      i_host.wr(`PSAT_CMD_LOOP_TUNING, 4, {32'h0, exp_t}, r);
      chk({r, ovr, tune}, {3'h5, exp_t});
      dres = ~dres;
      dload = 1'b1;
      @(negedge ref_clk_in);
      dload = 1'b0;
      chk(tune, exp_t);
      i_host.rd(`PSAT_CMD_LOOP_TUNING, 5, d, v);
      chk({v, d}, {8'h0f, 32'h0, exp_t});
      srst_in = 1'b1;
      @(negedge ref_clk_in);
      srst_in = 1'b0;
      chk({ovr, tune}, {1'b0, `PSAT_INTEG_RESET, `PSAT_RESID_RESET, `PSAT_GAIN_RESET});
      $display("tuning test done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
